//--- rtl/art_timer_regs.sv
// Auto-reload PWM timer: register file, counter, PWM and capture channels
// Overview of operation
// - Duty register places each PWM second edge
// - Four independent duty registers at 31h-34h
// - Capture control bits 7:6 read zero
// - Edge select: 0 falling, 1 rising
// - Per-channel capture interrupt enable bits
// - Flag set on capture, cleared by read
// - Capture register loads current counter value
// - All registers reset to zero
// - Timer registers at 35h through 3Bh
// - Further captures blocked until data read
// - Capture interrupt held while flag and enable
// - Counter counts up, reloads after FFh
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
module art_timer_regs #(
  parameter int unsigned NPWM = art_pkg::NUM_PWM,
  parameter int unsigned NCAP = art_pkg::NUM_CAP
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic [art_pkg::ADDR_W-1:0] addr_i,
  input wire logic [art_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [art_pkg::DATA_W-1:0] rdata_o,
  // Pins
  input wire logic ext_clk_i,
  input wire logic [NCAP-1:0] capture_input_pin_i,
  output logic [NPWM-1:0] pwm_o,
  output logic [NPWM-1:0] pwm_oe_o,
  // Interrupt
  output logic irq_o
);
  import art_pkg::*;

  logic rst_m_q, rst_s_q;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end
  logic rst_b;
  assign rst_b = rst_s_q;

  logic [DATA_W-1:0] duty_value_q [NPWM];
  logic [DATA_W-1:0] pwm_output_ctrl_reg_q;
  logic [DATA_W-1:0] reload_value_reg_q;
  logic [DATA_W-1:0] count_q;
  logic [TCS_PRE_LSB+2:TCS_RUN] tcs_ctl_q; // prescale, run
  logic external_clock_select_q;
  logic overflow_irq_enable_q;
  logic overflow_flag_q;
  logic [NCAP-1:0] capture_edge_q;
  logic [NCAP-1:0] capture_irq_enable_q;
  logic [NCAP-1:0] capture_flag_ch;
  logic [NCAP-1:0] cap_set;
  logic [NCAP-1:0] cap_rd;
  logic [DATA_W-1:0] capture_value [NCAP];
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [PRE_W-1:0] pre_q;
  logic ext_s1_q, ext_s2_q, ext_s3_q;
  logic tick, wrap, force_reload;
  logic wr_duty, wr_cnt;
  localparam int unsigned DUTY_IDX_W = $clog2(NPWM);

  // Duty registers, channel 3 at the lowest address
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NPWM; i++) duty_value_q[i] <= REG_RESET;
    end else if (wr_duty) begin
      duty_value_q[DUTY_IDX_W'(ADDR_DUTY0 - addr_i)] <= wdata_i;
    end
  end
  assign wr_duty = wr_i && addr_i >= ADDR_DUTY3 && addr_i <= ADDR_DUTY0;

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      pwm_output_ctrl_reg_q <= REG_RESET;
      reload_value_reg_q <= REG_RESET;
      tcs_ctl_q <= '0;
      external_clock_select_q <= 1'b0;
      overflow_irq_enable_q <= 1'b0;
      capture_edge_q <= '0;
      capture_irq_enable_q <= '0;
      irq_mask_q <= IRQ_RESET;
    end else if (wr_i) begin
      unique case (addr_i)
        ADDR_PWMCTL: pwm_output_ctrl_reg_q <= wdata_i;
        ADDR_RELOAD: reload_value_reg_q <= wdata_i;
        ADDR_TCS: begin
          external_clock_select_q <= wdata_i[TCS_EXTERNAL_CLOCK_SELECT];
          tcs_ctl_q <= wdata_i[TCS_PRE_LSB+2:TCS_RUN];
          overflow_irq_enable_q <= wdata_i[TCS_OIE];
        end
        ADDR_CAPCS: begin
          capture_edge_q <= wdata_i[CAP_EDGE_LSB +: NCAP];
          capture_irq_enable_q <= wdata_i[CAP_IE_LSB +: NCAP];
        end
        ADDR_IRQ_MASK: irq_mask_q <= wdata_i[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // External clock edge counts as prescaler input
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_clk_i;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  logic in_tick;
  logic [PRE_W:0] pre_mask;
  assign in_tick = external_clock_select_q ? (ext_s2_q & ~ext_s3_q) : 1'b1;
  assign pre_mask = (PRE_W+1)'((1 << tcs_ctl_q[TCS_PRE_LSB+2:TCS_PRE_LSB]) - 1);
  assign force_reload = wr_i && addr_i == ADDR_TCS && wdata_i[TCS_FRL];
  assign wr_cnt = wr_i && addr_i == ADDR_CNT;
  assign tick = tcs_ctl_q[TCS_RUN] && in_tick &&
                ((pre_q & pre_mask[PRE_W-1:0]) == pre_mask[PRE_W-1:0]);
  assign wrap = tick && count_q == CNT_MAX;

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      pre_q <= '0;
    end else if (force_reload || tick) begin
      pre_q <= '0;
    end else if (tcs_ctl_q[TCS_RUN] && in_tick) begin
      pre_q <= pre_q + PRE_W'(1);
    end
  end

  // Counter up, reload on wrap or forced reload
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= REG_RESET;
    end else if (force_reload || wrap) begin
      count_q <= reload_value_reg_q;
    end else if (wr_cnt) begin
      count_q <= wdata_i;
    end else if (tick) begin
      count_q <= count_q + CNT_ONE;
    end
  end

  logic ovf_rd;
  assign ovf_rd = rd_i && addr_i == ADDR_TCS;
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      overflow_flag_q <= 1'b0;
    end else if (wrap) begin
      overflow_flag_q <= 1'b1;
    end else if (ovf_rd) begin
      overflow_flag_q <= 1'b0;
    end
  end

  for (genvar c = 0; c < NCAP; c++) begin : g_cap
    assign cap_rd[c] = rd_i && addr_i == ADDR_CAP1 + ADDR_W'(c);
    art_cap_chan u_cap (
      .clk_i(clk_i),
      .rst_b_i(rst_b),
      .rising_i(capture_edge_q[c]),
      .rd_i(cap_rd[c]),
      .count_i(count_q),
      .pin_i(capture_input_pin_i[c]),
      .flag_o(capture_flag_ch[c]),
      .set_o(cap_set[c]),
      .value_o(capture_value[c])
    );
  end

  for (genvar p = 0; p < NPWM; p++) begin : g_pwm
    art_pwm_chan u_pwm (
      .clk_i(clk_i),
      .rst_b_i(rst_b),
      .count_i(count_q),
      .duty_value_i(duty_value_q[p]),
      .pwm_polarity_i(pwm_output_ctrl_reg_q[p]),
      .enable_i(pwm_output_ctrl_reg_q[PWM_OE_LSB + p]),
      .pwm_o(pwm_o[p]),
      .pwm_oe_o(pwm_oe_o[p])
    );
  end

  // Sticky status, write one to clear, set wins
  logic [IRQ_W-1:0] ev, w1c;
  assign ev = {cap_set, wrap};
  assign w1c = (wr_i && addr_i == ADDR_IRQ_STAT) ? wdata_i[IRQ_W-1:0] : IRQ_RESET;
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat_q <= IRQ_RESET;
    end else begin
      irq_stat_q <= (irq_stat_q & ~w1c) | ev;
    end
  end

  // Interrupt: masked sticky bits, plus level capture and overflow requests
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_q & irq_mask_q) ||
               |(capture_flag_ch & capture_irq_enable_q) ||
               (overflow_flag_q && overflow_irq_enable_q);
    end
  end

  // Read data, one cycle after strobe
  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = REG_RESET;
    unique case (addr_i)
      ADDR_DUTY3, ADDR_DUTY2, ADDR_DUTY1, ADDR_DUTY0:
        rd_mux = duty_value_q[DUTY_IDX_W'(ADDR_DUTY0 - addr_i)];
      ADDR_PWMCTL: rd_mux = pwm_output_ctrl_reg_q;
      ADDR_TCS: rd_mux = {external_clock_select_q, tcs_ctl_q, 1'b0,
                          overflow_irq_enable_q, overflow_flag_q};
      ADDR_CNT: rd_mux = count_q;
      ADDR_RELOAD: rd_mux = reload_value_reg_q;
      ADDR_CAPCS: rd_mux = {2'b00, capture_edge_q, capture_irq_enable_q,
                            capture_flag_ch};
      ADDR_CAP1: rd_mux = capture_value[0];
      ADDR_CAP2: rd_mux = capture_value[1];
      ADDR_IRQ_MASK: rd_mux = {{(DATA_W-IRQ_W){1'b0}}, irq_mask_q};
      ADDR_IRQ_STAT: rd_mux = {{(DATA_W-IRQ_W){1'b0}}, irq_stat_q};
      default: rd_mux = REG_RESET;
    endcase
  end
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      rdata_o <= REG_RESET;
    end else begin
      rdata_o <= rd_i ? rd_mux : REG_RESET;
    end
  end

  a_reload_wrap: assert property (@(posedge clk_i) disable iff (!rst_b)
    wrap && !wr_cnt |=> count_q == $past(reload_value_reg_q))
    else $error("counter did not reload");
  a_count_step: assert property (@(posedge clk_i) disable iff (!rst_b)
    tick && !wrap && !force_reload && !wr_cnt |=> count_q == $past(count_q) + CNT_ONE)
    else $error("counter did not step");
  a_cap_load: assert property (@(posedge clk_i) disable iff (!rst_b)
    cap_set[0] |=> capture_value[0] == $past(count_q) && capture_flag_ch[0])
    else $error("capture value wrong");
  a_cap2_load: assert property (@(posedge clk_i) disable iff (!rst_b)
    cap_set[1] |=> capture_value[1] == $past(count_q) && capture_flag_ch[1])
    else $error("second capture value wrong");
  a_flag_clear: assert property (@(posedge clk_i) disable iff (!rst_b)
    cap_rd[1] && !cap_set[1] |=> !capture_flag_ch[1])
    else $error("flag not cleared by read");
  a_irq_level: assert property (@(posedge clk_i) disable iff (!rst_b)
    (capture_flag_ch[0] && capture_irq_enable_q[0]) |=> irq_o)
    else $error("capture interrupt missing");
  a_irq_ch2: assert property (@(posedge clk_i) disable iff (!rst_b)
    (capture_flag_ch[1] && capture_irq_enable_q[1]) |=> irq_o)
    else $error("second capture interrupt missing");
  a_capcs_rsvd: assert property (@(posedge clk_i) disable iff (!rst_b)
    rd_i && addr_i == ADDR_CAPCS |=> rdata_o[7:6] == 2'b00)
    else $error("reserved bits nonzero");
  a_edge_bits: assert property (@(posedge clk_i) disable iff (!rst_b)
    wr_i && addr_i == ADDR_CAPCS |=> capture_edge_q == $past(wdata_i[5:4]) &&
    capture_irq_enable_q == $past(wdata_i[3:2]))
    else $error("capture control layout wrong");
  a_duty_write: assert property (@(posedge clk_i) disable iff (!rst_b)
    wr_i && addr_i == ADDR_DUTY3 |=> duty_value_q[3] == $past(wdata_i))
    else $error("duty register write lost");
  a_pwm_oe: assert property (@(posedge clk_i) disable iff (!rst_b)
    !pwm_output_ctrl_reg_q[PWM_OE_LSB] |=> !pwm_oe_o[0] && !pwm_o[0])
    else $error("pwm driven while disabled");
  a_pwm_level: assert property (@(posedge clk_i) disable iff (!rst_b)
    pwm_output_ctrl_reg_q[PWM_OE_LSB] |=>
    pwm_o[0] == (($past(count_q) <= $past(duty_value_q[0])) ^ $past(pwm_output_ctrl_reg_q[0])))
    else $error("pwm level wrong");
  a_ovf_set: assert property (@(posedge clk_i) disable iff (!rst_b)
    wrap |=> overflow_flag_q)
    else $error("overflow flag not set");
  a_ovf_clear: assert property (@(posedge clk_i) disable iff (!rst_b)
    ovf_rd && !wrap |=> !overflow_flag_q)
    else $error("overflow flag not cleared by read");
  a_read_idle: assert property (@(posedge clk_i) disable iff (!rst_b)
    !rd_i |=> rdata_o == REG_RESET)
    else $error("read data outside read cycle");
  c_capture: cover property (@(posedge clk_i) disable iff (!rst_b) cap_set[0]);
  c_cap2: cover property (@(posedge clk_i) disable iff (!rst_b) cap_set[1]);
  c_wrap: cover property (@(posedge clk_i) disable iff (!rst_b) wrap);
  c_irq: cover property (@(posedge clk_i) disable iff (!rst_b) $rose(irq_o));
  c_pwm_inverted: cover property (@(posedge clk_i) disable iff (!rst_b)
    pwm_oe_o[1] && pwm_o[1] && pwm_output_ctrl_reg_q[1]);
endmodule : art_timer_regs

//--- include/art_pkg.sv
// Register map, field layout and reset values of the auto-reload PWM timer
package art_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_PWM = 4;
  localparam int unsigned NUM_CAP = 2;
  localparam logic [ADDR_W-1:0] ADDR_DUTY3 = 8'h31;
  localparam logic [ADDR_W-1:0] ADDR_DUTY2 = 8'h32;
  localparam logic [ADDR_W-1:0] ADDR_DUTY1 = 8'h33;
  localparam logic [ADDR_W-1:0] ADDR_DUTY0 = 8'h34;
  localparam logic [ADDR_W-1:0] ADDR_PWMCTL = 8'h35;
  localparam logic [ADDR_W-1:0] ADDR_TCS = 8'h36;
  localparam logic [ADDR_W-1:0] ADDR_CNT = 8'h37;
  localparam logic [ADDR_W-1:0] ADDR_RELOAD = 8'h38;
  localparam logic [ADDR_W-1:0] ADDR_CAPCS = 8'h39;
  localparam logic [ADDR_W-1:0] ADDR_CAP1 = 8'h3A;
  localparam logic [ADDR_W-1:0] ADDR_CAP2 = 8'h3B;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h3C;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h3D;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] CNT_MAX = 8'hFF;
  localparam logic [DATA_W-1:0] CNT_ONE = 8'h01;
  // Capture control/status field positions
  localparam int unsigned CAP_EDGE_LSB = 4;
  localparam int unsigned CAP_IE_LSB = 2;
  localparam int unsigned CAP_FLAG_LSB = 0;
  // Timer control/status field positions
  localparam int unsigned TCS_EXTERNAL_CLOCK_SELECT = 7;
  localparam int unsigned TCS_PRE_LSB = 4;
  localparam int unsigned TCS_RUN = 3;
  localparam int unsigned TCS_FRL = 2;
  localparam int unsigned TCS_OIE = 1;
  localparam int unsigned TCS_OVF = 0;
  localparam int unsigned PWM_OE_LSB = 4;
  localparam int unsigned PRE_W = 7;
  // Interrupt status bits: ovf, cap1, cap2
  localparam int unsigned IRQ_W = 3;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;
endpackage : art_pkg

//--- rtl/art_cap_chan.sv
// One input capture channel: edge detect, latch, flag
`timescale 1ns/1ps
module art_cap_chan (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Control
  input wire logic rising_i,
  input wire logic rd_i,
  input wire logic [art_pkg::DATA_W-1:0] count_i,
  // Pin
  input wire logic pin_i,
  // Results
  output logic flag_o,
  output logic set_o,
  output logic [art_pkg::DATA_W-1:0] value_o
);
  import art_pkg::*;
  logic s1_q, s2_q, s3_q;
  logic edge_hit;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // Edge polarity from the edge-select bit
  assign edge_hit = rising_i ? (s2_q & ~s3_q) : (~s2_q & s3_q);
  assign set_o = edge_hit & ~flag_o;
  // Latch counter only while flag clear
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      value_o <= REG_RESET;
    end else if (set_o) begin
      value_o <= count_i;
    end
  end
  // Set wins over read clear
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flag_o <= 1'b0;
    end else if (set_o) begin
      flag_o <= 1'b1;
    end else if (rd_i) begin
      flag_o <= 1'b0;
    end
  end
  a_flag_blocks: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    flag_o && !rd_i |=> flag_o && $stable(value_o))
    else $error("capture changed while flag set");
endmodule : art_cap_chan

//--- rtl/art_pwm_chan.sv
// One PWM output channel: compare against duty, polarity, enable
`timescale 1ns/1ps
module art_pwm_chan (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Control
  input wire logic [art_pkg::DATA_W-1:0] count_i,
  input wire logic [art_pkg::DATA_W-1:0] duty_value_i,
  input wire logic pwm_polarity_i,
  input wire logic enable_i,
  // Pin
  output logic pwm_o,
  output logic pwm_oe_o
);
  import art_pkg::*;
  logic level;
  // High while counter at or below duty, low after; polarity inverts
  assign level = (count_i <= duty_value_i) ^ pwm_polarity_i;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pwm_o <= 1'b0;
      pwm_oe_o <= 1'b0;
    end else begin
      pwm_o <= level & enable_i;
      pwm_oe_o <= enable_i;
    end
  end
endmodule : art_pwm_chan

//--- tb/art_pin_model.sv
// Pin-side model: drives capture pins, counts driven-high PWM cycles
`timescale 1ns/1ps
module art_pin_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Stimulus from bench
  input wire logic [1:0] level_i,
  input wire logic clr_i,
  // From timer pins
  input wire logic [3:0] pwm_i,
  input wire logic [3:0] pwm_oe_i,
  // To timer pins, and high counts to bench
  output logic [1:0] pin_o,
  output logic [3:0][7:0] high_cnt_o
);
  // Capture pins change only just after an edge
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_o <= 2'h0;
    end else begin
      pin_o <= level_i;
    end
  end
  // Counts cycles where a pin is driven and high
  always_ff @(posedge clk_i) begin
    for (int p = 0; p < 4; p++) begin
      if (clr_i) begin
        high_cnt_o[p] <= 8'h00;
      end else if (pwm_oe_i[p] && pwm_i[p]) begin
        high_cnt_o[p] <= high_cnt_o[p] + 8'h01;
      end
    end
  end
endmodule : art_pin_model

//--- tb/art_timer_regs_test.sv
// Self-checking bench of the timer register block
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module art_timer_regs_test;
  import art_pkg::*;
  logic clk_i;
  logic rst_b_i;
  logic [7:0] addr_i;
  logic [7:0] wdata_i;
  logic wr_i;
  logic rd_i;
  logic [7:0] rdata_o;
  logic [1:0] pins;
  logic [1:0] level;
  logic clr;
  logic [3:0] pwm_o;
  logic [3:0] pwm_oe_o;
  logic irq_o;
  logic ext_clk;
  logic [3:0][7:0] high_cnt;
  int n_errors = 0;
  int check_count = 0;
  art_timer_regs u_dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_clk_i(ext_clk),
    .capture_input_pin_i(pins), .pwm_o(pwm_o), .pwm_oe_o(pwm_oe_o), .irq_o(irq_o)
  );
  art_pin_model u_pins (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .level_i(level), .clr_i(clr),
    .pwm_i(pwm_o), .pwm_oe_i(pwm_oe_o), .pin_o(pins), .high_cnt_o(high_cnt)
  );
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
    `CHK(d, e)
    @(posedge clk_i);
  endtask : rd
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  initial begin
    #200us;
    n_errors++;
    test_done();
  end
  initial begin
    rst_b_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    level = 2'h0;
    clr = 1'b1;
    ext_clk = 1'b0;
    cyc(8);
    rst_b_i <= 1'b1;
    cyc(3);
    // Reset values over the map and beyond
    for (int a = 8'h30; a <= 8'h3E; a++) begin
      rd(a[7:0], 8'h00);
    end
    #1 `CHK(irq_o, 1'b0)
    // Duty registers hold their own values
    wr(ADDR_DUTY3, 8'hFF);
    wr(ADDR_DUTY2, 8'h24);
    wr(ADDR_DUTY1, 8'h35);
    wr(ADDR_DUTY0, 8'h46);
    wr(8'h40, 8'h77);
    wr(ADDR_CAP1, 8'h99);
    rd(ADDR_DUTY3, 8'hFF);
    rd(ADDR_DUTY2, 8'h24);
    rd(ADDR_DUTY1, 8'h35);
    rd(ADDR_DUTY0, 8'h46);
    rd(8'h40, 8'h00);
    rd(ADDR_CAP1, 8'h00);
    // Reserved and flag bits not writable
    wr(ADDR_CAPCS, 8'hFF);
    rd(ADDR_CAPCS, 8'h3C);
    // Ch1 rising, ch2 falling, both enabled; counter frozen
    wr(ADDR_CAPCS, 8'h1C);
    wr(ADDR_CNT, 8'h55);
    rd(ADDR_CNT, 8'h55);
    level <= 2'h2;
    cyc(8);
    rd(ADDR_CAPCS, 8'h1C);
    level <= 2'h3;
    cyc(8);
    rd(ADDR_CAPCS, 8'h1D);
    #1 `CHK(irq_o, 1'b1)
    // Second capture while flag set is blocked
    wr(ADDR_CNT, 8'h66);
    level <= 2'h2;
    cyc(4);
    level <= 2'h3;
    cyc(8);
    rd(ADDR_CAP1, 8'h55);
    rd(ADDR_CAPCS, 8'h1C);
    cyc(3);
    #1 `CHK(irq_o, 1'b0)
    // Ch2 falling edge with its enable on, then its enable turned off
    level <= 2'h1;
    cyc(8);
    rd(ADDR_CAPCS, 8'h1E);
    wr(ADDR_CAPCS, 8'h14);
    cyc(3);
    #1 `CHK(irq_o, 1'b0)
    rd(ADDR_CAP2, 8'h66);
    rd(ADDR_CAPCS, 8'h14);
    // Sticky status, mask, write one to clear
    rd(ADDR_IRQ_STAT, 8'h06);
    wr(ADDR_IRQ_MASK, 8'h04);
    cyc(3);
    #1 `CHK(irq_o, 1'b1)
    wr(ADDR_IRQ_STAT, 8'h06);
    cyc(3);
    #1 `CHK(irq_o, 1'b0)
    rd(ADDR_IRQ_STAT, 8'h00);
    // PWM: reload F0h, ch0 duty F8h, ch1 duty 0 inverted, ch2/ch3 off
    wr(ADDR_RELOAD, 8'hF0);
    wr(ADDR_DUTY0, 8'hF8);
    wr(ADDR_DUTY1, 8'h00);
    wr(ADDR_PWMCTL, 8'h32);
    wr(ADDR_TCS, 8'h0C);
    cyc(20);
    clr <= 1'b0;
    cyc(32);
    clr <= 1'b1;
    #1 `CHK(high_cnt[0], 8'h12)
    `CHK(high_cnt[1], 8'h20)
    `CHK(high_cnt[2], 8'h00)
    `CHK(pwm_oe_o, 4'h3)
    `CHK(pwm_o[3:2], 2'h0)
    // Overflow flag cleared by reading
    wr(ADDR_TCS, 8'h00);
    rd(ADDR_TCS, 8'h01);
    rd(ADDR_TCS, 8'h00);
    // Prescale by two: one step in two clocks
    wr(ADDR_TCS, 8'h1C);
    wr(ADDR_TCS, 8'h10);
    rd(ADDR_CNT, 8'hF1);
    rd(ADDR_TCS, 8'h10);
    // External clock: one step per rising edge
    wr(ADDR_TCS, 8'h8C);
    repeat (3) begin
      ext_clk <= 1'b1;
      cyc(4);
      ext_clk <= 1'b0;
      cyc(4);
    end
    wr(ADDR_TCS, 8'h80);
    rd(ADDR_CNT, 8'hF3);
    rd(ADDR_TCS, 8'h80);
    test_done();
  end
endmodule : art_timer_regs_test
